// [dv/blr_eeprom_model.sv]
// Behavioural three-wire serial EEPROM that answers on its data output line
`default_nettype none
module blr_eeprom_model (
   // Serial lines from the block
   input  wire logic sel,
   input  wire logic sclk,
   input  wire logic sdi,
   // Data back to the block
   output logic      sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   logic bit_r;
   initial bit_r = 1'b0;
   always @(posedge sclk) begin
      if (sel) begin
         bit_r <= sdi;
      end
   end
   // Deselected output shows the inverse, so a stale bit never reads as valid
   assign sdo = sel ? bit_r : ~bit_r;
endmodule
`default_nettype wire

// [dv/blr_regs_tb.sv]
// Self-checking bench for the LED, EEPROM line and reset cause ports
`default_nettype none
module blr_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ST_TAB [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h08, 8'h04};
   localparam logic [2:0] COL_TAB [6] = '{3'h2, 3'h1, 3'h6, 3'h4, 3'h3, 3'h5};
   localparam logic [7:0] CS_TAB [7] = '{8'hF2, 8'h42, 8'h22, 8'h12, 8'hFA, 8'h02, 8'h01};
   logic                   clk, rst_n, stby_por_n, io_wr, io_rd, jumper, pwr_req;
   logic                   io_rvalid, ps_o, ps_oe, ee_cs, ee_sk, ee_di, ee_do;
   logic [15:0]            io_addr;
   logic [7:0]             io_wdata, io_rdata, e;
   blr_pkg::blr_status_t   status;
   blr_pkg::blr_cause_in_t cause_in;
   blr_pkg::blr_rgb_t      led;
   int                     mismatches, check_count, n_on, n_off;

   blr_regs #(.BLINK_HALF(4)) uut (.CLK(clk), .RST_N(rst_n), .STBY_POR_N(stby_por_n),
      .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata),
      .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid), .STATUS(status), .CAUSE_IN(cause_in),
      .DEFAULT_CONFIG_JUMPER(jumper), .PWR_ON_REQ(pwr_req), .POWER_SUPPLY_ON_N_O(ps_o),
      .POWER_SUPPLY_ON_N_OE(ps_oe), .EEPROM_CS(ee_cs), .EEPROM_SERIAL_CLOCK(ee_sk),
      .EEPROM_SERIAL_IN(ee_di), .EEPROM_SERIAL_OUT(ee_do), .LED(led));
   blr_eeprom_model eeprom (.sel(ee_cs), .sclk(ee_sk), .sdi(ee_di), .sdo(ee_do));

   task automatic end_of_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_led(input logic [2:0] exp);
      #1;
      chk({5'h00, led}, {5'h00, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1;
      chk({7'h00, io_rvalid}, 8'h01);
      chk(io_rdata & m, exp);
   endtask
   task automatic board_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      cyc(20000);
      mismatches++;
      end_of_test();
   end
   initial begin
      rst_n = 1'b0;
      stby_por_n = 1'b0;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      status = 8'h00;
      cause_in = 7'h00;
      jumper = 1'b0;
      pwr_req = 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      stby_por_n <= 1'b1;
      rd(16'h0457, 8'hFF, 8'h00);
      rd(16'h0450, 8'hFF, 8'h00);
      for (int k = 8; k < 16; k++) begin
         wr(16'h0456, 8'(k));
         cyc(3);
         chk_led(3'(k));
         rd(16'h0456, 8'hEF, 8'(k));
      end
      wr(16'h0456, 8'h00);
      for (int i = 0; i < 6; i++) begin
         status <= ST_TAB[i];
         cyc(6);
         chk_led(COL_TAB[i]);
      end
      status <= 8'h02;
      cyc(4);
      n_on = 0;
      n_off = 0;
      repeat (16) begin
         @(posedge clk);
         #1;
         if (led === 3'h2) n_on++;
         else if (led === 3'h0) n_off++;
      end
      chk(8'(n_on), 8'h08);
      chk(8'(n_off), 8'h08);
      status <= 8'h80;
      cyc(6);
      chk_led(3'h7);
      status <= 8'h00;
      cyc(6);
      chk_led(3'h7);
      status <= 8'h01;
      cyc(6);
      chk_led(3'h2);
      status <= 8'h00;
      for (int i = 0; i < 7; i++) begin
         e = CS_TAB[i];
         cause_in <= 7'h40 >> i;
         cyc(4);
         cause_in <= 7'h00;
         cyc(4);
         rd(16'h0457, 8'hFF, e);
         wr(16'h0457, 8'h00);
         rd(16'h0457, 8'hFF, e);
         wr(16'h0457, e & (~e + 8'h01));
         rd(16'h0457, 8'hFF, e & (e - 8'h01));
         wr(16'h0457, 8'hFF);
         rd(16'h0457, 8'hFF, 8'h00);
      end
      cause_in <= 7'h01;
      cyc(4);
      wr(16'h0457, 8'hFF);
      rd(16'h0457, 8'hFF, 8'h01);
      cause_in <= 7'h00;
      cyc(4);
      wr(16'h0457, 8'hFF);
      rd(16'h0457, 8'hFF, 8'h00);
      cause_in <= 7'h40;
      cyc(4);
      cause_in <= 7'h00;
      jumper <= 1'b1;
      board_reset();
      cyc(6);
      chk_led(3'h4);
      rd(16'h0457, 8'hFF, 8'hF2);
      jumper <= 1'b0;
      board_reset();
      cyc(6);
      chk_led(3'h2);
      @(posedge clk);
      stby_por_n <= 1'b0;
      cyc(2);
      stby_por_n <= 1'b1;
      rd(16'h0457, 8'hFF, 8'h00);
      wr(16'h0456, 8'hA0);
      wr(16'h0456, 8'hE0);
      #1;
      chk({5'h00, ee_cs, ee_sk, ee_di}, 8'h07);
      cyc(3);
      rd(16'h0456, 8'hFF, 8'hF0);
      wr(16'h0456, 8'h80);
      wr(16'h0456, 8'hD0);
      cyc(3);
      rd(16'h0456, 8'hFF, 8'hC0);
      wr(16'h0456, 8'h00);
      pwr_req <= 1'b1;
      cyc(2);
      #1;
      chk({6'h00, ps_oe, ps_o}, 8'h02);
      pwr_req <= 1'b0;
      cyc(2);
      #1;
      chk({6'h00, ps_oe, ps_o}, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire

// [verilog/blr_pkg.sv]
// Package: addresses, field positions, reset values and types of the board register block
`default_nettype none
package blr_pkg;
   // I/O port addresses
   localparam logic [15:0] LED_PORT_ADDR   = 16'h0456;
   localparam logic [15:0] CAUSE_PORT_ADDR = 16'h0457;

   // Shared LED/EEPROM port fields
   localparam int          EE_CS_BIT       = 7;
   localparam int          EE_SK_BIT       = 6;
   localparam int          EE_DI_BIT       = 5;
   localparam int          EE_DO_BIT       = 4;
   localparam int          LED_MAN_BIT     = 3;
   localparam logic [7:0]  PORT_WR_MASK    = 8'hEF;
   localparam logic [7:0]  PORT_RESET      = 8'h00;

   // Reset cause fields
   localparam int          C_MAIN          = 7;
   localparam int          C_CORE          = 6;
   localparam int          C_NSTBY         = 5;
   localparam int          C_MEM           = 4;
   localparam int          C_STBY          = 3;
   localparam int          C_RSVD          = 2;
   localparam int          C_PCI           = 1;
   localparam int          C_BTN           = 0;
   localparam logic [7:0]  CAUSE_MASK      = 8'hFB;
   localparam logic [7:0]  CAUSE_RESET     = 8'h00;
   localparam logic [7:0]  SET_STBY        = 8'hFA;
   localparam logic [7:0]  SET_MAIN        = 8'hF2;
   localparam logic [7:0]  SET_CORE        = 8'h42;
   localparam logic [7:0]  SET_NSTBY       = 8'h22;
   localparam logic [7:0]  SET_MEM         = 8'h12;
   localparam logic [7:0]  SET_PCI         = 8'h02;
   localparam logic [7:0]  SET_BTN         = 8'h01;

   // Timing
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          BLINK_HALF_MS   = 100;
   localparam int          BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam logic [1:0]  JUMPER_CAP_CYC  = 2'h3;

   typedef struct packed {
      logic r;
      logic g;
      logic b;
   } blr_rgb_t;

   localparam blr_rgb_t    RGB_OFF         = 3'h0;
   localparam blr_rgb_t    RGB_BLUE        = 3'h1;
   localparam blr_rgb_t    RGB_GREEN       = 3'h2;
   localparam blr_rgb_t    RGB_CYAN        = 3'h3;
   localparam blr_rgb_t    RGB_RED         = 3'h4;
   localparam blr_rgb_t    RGB_MAGENTA     = 3'h5;
   localparam blr_rgb_t    RGB_YELLOW      = 3'h6;
   localparam blr_rgb_t    RGB_WHITE       = 3'h7;

   typedef struct packed {
      logic thermal;
      logic in_reset;
      logic standby;
      logic disk;
      logic link10;
      logic link100;
      logic activity;
      logic shutdown;
   } blr_status_t;

   typedef struct packed {
      logic main_fail;
      logic core_fail;
      logic nstby_fail;
      logic mem_fail;
      logic stby_fail;
      logic pci_reset;
      logic button;
   } blr_cause_in_t;
endpackage
`default_nettype wire

// [verilog/blr_regs.sv]
// Board LED, EEPROM line and reset cause register block on two I/O ports
`default_nettype none
module blr_regs #(
   parameter int BLINK_HALF = blr_pkg::BLINK_HALF_CYC
) (
   // Clock and resets
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   input  wire logic                   STBY_POR_N,
   // Host I/O port access
   input  wire logic [15:0]            IO_ADDR,
   input  wire logic                   IO_WR,
   input  wire logic                   IO_RD,
   input  wire logic [7:0]             IO_WDATA,
   output logic      [7:0]             IO_RDATA,
   output logic                        IO_RVALID,
   // Board status and reset sources
   input  wire blr_pkg::blr_status_t   STATUS,
   input  wire blr_pkg::blr_cause_in_t CAUSE_IN,
   input  wire logic                   DEFAULT_CONFIG_JUMPER,
   input  wire logic                   PWR_ON_REQ,
   // Supply control pin
   output logic                        POWER_SUPPLY_ON_N_O,
   output logic                        POWER_SUPPLY_ON_N_OE,
   // Serial EEPROM lines
   output logic                        EEPROM_CS,
   output logic                        EEPROM_SERIAL_CLOCK,
   output logic                        EEPROM_SERIAL_IN,
   input  wire logic                   EEPROM_SERIAL_OUT,
   // Tri-colour LED
   output blr_pkg::blr_rgb_t           LED
);
   localparam int BW = $clog2(BLINK_HALF);

   // Elaboration check: the blink divider needs at least two counts
   if (BLINK_HALF < 2) begin : g_bad_blink
      $error("BLINK_HALF must be at least 2");
   end

   // Synchronisers
   blr_pkg::blr_status_t   stat_meta_r, stat_s;
   blr_pkg::blr_cause_in_t cause_meta_r, cause_s;
   logic [1:0]             misc_meta_r, misc_s;
   logic                   jumper_s, ee_do_s;

   assign jumper_s = misc_s[1];
   assign ee_do_s  = misc_s[0];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         stat_meta_r <= '0;
         stat_s      <= '0;
         misc_meta_r <= 2'h0;
         misc_s      <= 2'h0;
      end else begin
         stat_meta_r <= STATUS;
         stat_s      <= stat_meta_r;
         misc_meta_r <= {DEFAULT_CONFIG_JUMPER, EEPROM_SERIAL_OUT};
         misc_s      <= misc_meta_r;
      end
   end

   always_ff @(posedge CLK) begin
      if (!STBY_POR_N) begin
         cause_meta_r <= '0;
         cause_s      <= '0;
      end else begin
         cause_meta_r <= CAUSE_IN;
         cause_s      <= cause_meta_r;
      end
   end

   // Address decode
   logic hit_port, hit_cause, wr_port, wr_cause;
   assign hit_port  = (IO_ADDR == blr_pkg::LED_PORT_ADDR);
   assign hit_cause = (IO_ADDR == blr_pkg::CAUSE_PORT_ADDR);
   assign wr_port   = IO_WR && hit_port;
   assign wr_cause  = IO_WR && hit_cause;

   // Shared port register; software keeps the upper bits when changing the LED
   logic [7:0] port_r, port_rd;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         port_r <= blr_pkg::PORT_RESET;
      end else if (wr_port) begin
         port_r <= IO_WDATA & blr_pkg::PORT_WR_MASK;
      end
   end
   assign port_rd = port_r | ({7'h00, ee_do_s} << blr_pkg::EE_DO_BIT);

   assign EEPROM_CS           = port_r[blr_pkg::EE_CS_BIT];
   assign EEPROM_SERIAL_CLOCK = port_r[blr_pkg::EE_SK_BIT];
   assign EEPROM_SERIAL_IN    = port_r[blr_pkg::EE_DI_BIT];

   // Reset cause flags, held on the standby reset only
   logic [7:0] cause_r, cause_set, cause_nxt;
   assign cause_set = (cause_s.stby_fail  ? blr_pkg::SET_STBY  : 8'h00)
                    | (cause_s.main_fail  ? blr_pkg::SET_MAIN  : 8'h00)
                    | (cause_s.core_fail  ? blr_pkg::SET_CORE  : 8'h00)
                    | (cause_s.nstby_fail ? blr_pkg::SET_NSTBY : 8'h00)
                    | (cause_s.mem_fail   ? blr_pkg::SET_MEM   : 8'h00)
                    | (cause_s.pci_reset  ? blr_pkg::SET_PCI   : 8'h00)
                    | (cause_s.button     ? blr_pkg::SET_BTN   : 8'h00);
   // Set wins over a simultaneous clear
   assign cause_nxt = ((cause_r & ~(wr_cause ? IO_WDATA : 8'h00)) | cause_set)
                    & blr_pkg::CAUSE_MASK;

   always_ff @(posedge CLK) begin
      if (!STBY_POR_N) begin
         cause_r <= blr_pkg::CAUSE_RESET;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // Read path
   logic [7:0] rd_mux;
   assign rd_mux = hit_port ? port_rd : (hit_cause ? cause_r : 8'h00);
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         IO_RDATA  <= 8'h00;
         IO_RVALID <= 1'b0;
      end else begin
         IO_RVALID <= IO_RD;
         if (IO_RD) begin
            IO_RDATA <= rd_mux;
         end
      end
   end

   // Supply-on request, drives the pin low only
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         POWER_SUPPLY_ON_N_OE <= 1'b0;
      end else begin
         POWER_SUPPLY_ON_N_OE <= PWR_ON_REQ;
      end
   end
   assign POWER_SUPPLY_ON_N_O = 1'b0;

   // Jumper caught shortly after board reset (RST_N) release
   logic [1:0] cap_cnt_r;
   logic       jumper_red_r, cap_done;
   assign cap_done = (cap_cnt_r == blr_pkg::JUMPER_CAP_CYC);
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cap_cnt_r    <= 2'h0;
         jumper_red_r <= 1'b0;
      end else if (!cap_done) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         if (cap_cnt_r == blr_pkg::JUMPER_CAP_CYC - 2'h1) begin
            jumper_red_r <= jumper_s;
         end
      end
   end

   // Thermal indication latch
   logic thermal_r;
   always_ff @(posedge CLK) begin
      if (!RST_N || stat_s.shutdown) begin
         thermal_r <= 1'b0;
      end else if (stat_s.thermal) begin
         thermal_r <= 1'b1;
      end
   end

   // Blink phase divider
   logic [BW-1:0] blink_cnt_r;
   logic          blink_ph_r, blink_end;
   assign blink_end = (blink_cnt_r == BW'(BLINK_HALF - 1));
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         blink_cnt_r <= '0;
         blink_ph_r  <= 1'b0;
      end else begin
         blink_cnt_r <= blink_end ? '0 : blink_cnt_r + BW'(1);
         if (blink_end) begin
            blink_ph_r <= ~blink_ph_r;
         end
      end
   end

   // Colour selection
   blr_pkg::blr_rgb_t auto_rgb, led_nxt;
   logic              manual, hold_red, blink_dark;
   assign manual   = port_r[blr_pkg::LED_MAN_BIT];
   assign hold_red = jumper_red_r || stat_s.in_reset;
   assign auto_rgb = thermal_r        ? blr_pkg::RGB_WHITE   :
                     hold_red         ? blr_pkg::RGB_RED     :
                     stat_s.standby   ? blr_pkg::RGB_YELLOW  :
                     stat_s.disk      ? blr_pkg::RGB_BLUE    :
                     stat_s.link100   ? blr_pkg::RGB_MAGENTA :
                     stat_s.link10    ? blr_pkg::RGB_CYAN    :
                                        blr_pkg::RGB_GREEN;
   assign blink_dark = stat_s.activity && blink_ph_r && !thermal_r && !hold_red;
   assign led_nxt  = manual     ? blr_pkg::blr_rgb_t'(port_r[2:0]) :
                     blink_dark ? blr_pkg::RGB_OFF : auto_rgb;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         LED <= blr_pkg::RGB_OFF;
      end else begin
         LED <= led_nxt;
      end
   end

   // Checks
   sequence s_cause_clear_all;
      wr_cause && (IO_WDATA == 8'hFF) && (cause_set == 8'h00);
   endsequence

   sequence s_cause_read;
      IO_RD && hit_cause && !IO_WR;
   endsequence

   a_manual_colour: assert property (@(posedge CLK) disable iff (!RST_N)
      manual |=> (LED == $past(port_r[2:0])))
      else $error("manual colour does not follow selector");

   a_auto_green: assert property (@(posedge CLK) disable iff (!RST_N)
      (!manual && !thermal_r && !hold_red && !stat_s.standby && !stat_s.disk
       && !stat_s.link10 && !stat_s.link100 && !stat_s.activity) |=> (LED == 3'h2))
      else $error("idle auto colour is not green");

   a_thermal_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (thermal_r && !stat_s.shutdown) |=> thermal_r)
      else $error("white indication dropped before shutdown");

   a_thermal_white: assert property (@(posedge CLK) disable iff (!RST_N)
      (thermal_r && !manual) |=> (LED == 3'h7))
      else $error("thermal latch not shown white");

   a_jumper_red: assert property (@(posedge CLK) disable iff (!RST_N)
      (jumper_red_r && !thermal_r && !manual) |=> (LED == 3'h4))
      else $error("jumper at power-up not shown red");

   a_cause_read: assert property (@(posedge CLK) disable iff (!RST_N || !STBY_POR_N)
      s_cause_read |=> (IO_RVALID && IO_RDATA == $past(cause_r)))
      else $error("cause read returned wrong value");

   a_cause_clear: assert property (@(posedge CLK) disable iff (!STBY_POR_N)
      s_cause_clear_all |=> (cause_r == 8'h00))
      else $error("write of ones did not clear causes");

   a_cause_keep: assert property (@(posedge CLK) disable iff (!STBY_POR_N)
      (wr_cause && IO_WDATA == 8'h00) |=> ((cause_r & $past(cause_r)) == $past(cause_r)))
      else $error("write of zero cleared a cause");

   a_rsvd_zero: assert property (@(posedge CLK) disable iff (!STBY_POR_N)
      cause_r[blr_pkg::C_RSVD] == 1'b0)
      else $error("reserved cause bit set");

   a_stby_cascade: assert property (@(posedge CLK) disable iff (!STBY_POR_N)
      cause_s.stby_fail |=> ((cause_r & 8'hFA) == 8'hFA))
      else $error("standby failure did not cascade");

   a_button_set: assert property (@(posedge CLK) disable iff (!STBY_POR_N)
      cause_s.button |=> cause_r[blr_pkg::C_BTN] ##1 cause_r[blr_pkg::C_BTN] || $past(wr_cause))
      else $error("button press not recorded");

   a_supply_on: assert property (@(posedge CLK) disable iff (!RST_N)
      PWR_ON_REQ |=> (POWER_SUPPLY_ON_N_OE && !POWER_SUPPLY_ON_N_O))
      else $error("supply-on pin not pulled low");

   a_eeprom_lines: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_port |=> ({EEPROM_CS, EEPROM_SERIAL_CLOCK, EEPROM_SERIAL_IN} == $past(IO_WDATA[7:5])))
      else $error("EEPROM lines do not follow port write");
endmodule
`default_nettype wire
